/* verilog/pct_pkg.sv */
// Package of offsets, field positions and reset values for the config header slice
package pct_pkg;
    // Dword addresses (byte offset bits 7:2) of the implemented config dwords
    localparam logic [5:0] TENURE_DWORD = 6'h03; // 0Ch dword: tenure/line + layout/self test
    localparam logic [5:0] HOST_BASE_DWORD = 6'h04; // 10h
    localparam logic [5:0] EXT_BASE_DWORD = 6'h05; // 14h
    // Byte offsets of the registers
    localparam logic [7:0] TENURE_OFFSET = 8'h0c;
    localparam logic [7:0] LAYOUT_OFFSET = 8'h0e;
    localparam logic [7:0] HOST_BASE_OFFSET = 8'h10;
    localparam logic [7:0] EXT_BASE_OFFSET = 8'h14;
    // Reset values
    localparam logic [15:0] TENURE_RESET = 16'h0000;
    localparam logic [20:0] POINTER_RESET = 21'h000000;
    // Fixed read values
    localparam logic [7:0] SELF_TEST_VALUE = 8'h00;
    localparam logic [7:0] LAYOUT_VALUE = 8'h00;
    localparam logic [6:0] WINDOW_SIZE_VALUE = 7'h00;
    localparam logic PREFETCH_VALUE = 1'b0;
    localparam logic [1:0] LOCATABLE_VALUE = 2'h0;
    localparam logic SPACE_VALUE = 1'b0;
    // Field positions of the base registers
    localparam int POINTER_LSB = 11;
    localparam int POINTER_WIDTH = 21;
    // Field positions of the tenure register
    localparam int TENURE_LIMIT_LSB = 8;
    // PCI memory command encodings
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;
endpackage

/* verilog/pct_config_header.sv */
// Config header slice: tenure/line register, layout/self test, two window bases
`timescale 1ns/10ps
`default_nettype none

// This slice answers config reads and writes for dwords 0Ch, 10h and 14h.
// Reads answer one clock after the request; other dwords read zero.
// Fixed fields are rebuilt on every read, so no write can disturb them.
// The two window bases also steer target decode of memory cycles.
// The tenure counter runs only while our own transaction is active.
// Grant loss alone never ends a transaction; the limit must be reached too.
// The line length is only handed on; burst sizing lives in the initiator.
// Every output comes straight from a flip-flop.

// Notes on behaviour
// R1: Writable tenure limit in upper byte 0Ch
// R2: Tenure counter restarts at frame, counts clocks
// R3: Limit reached and grant gone ends transaction
// R4: Low byte is line length for line commands
// R5: Tenure/line register read/write, resets to zero
// R6: Self test byte reads zero, ignores writes
// R7: Layout byte reads zero, ignores writes
// R8: All ones write reads back FFFF F800h
// R9: Only bits 31..11 of base writable
// R10: Bits 10..4 read zero, 2K window
// R11: Bit 3 reads zero, nonprefetchable
// R12: Bits 2..1 read zero, 32-bit locatable
// R13: Bit 0 reads zero, memory space
// R14: Host base at 10h, resets zero
// R15: Extension base at 14h, same layout
// R16: Claim memory cycles hitting either window
// R17: Writes honour byte enables, keep fixed bits
module pct_config_header (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Configuration access port
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic [5:0] cfg_dword,
    input wire logic [3:0] cfg_byte_enable_n,
    input wire logic [31:0] cfg_write_data,
    output logic [31:0] cfg_read_data,
    output logic cfg_read_valid,
    // Target address decode
    input wire logic target_addr_valid,
    input wire logic [31:0] target_addr,
    input wire logic [3:0] target_command,
    output logic host_window_hit,
    output logic ext_window_hit,
    // Initiator tenure control
    input wire logic initiator_frame_start,
    input wire logic initiator_active,
    input wire logic grant_n,
    output logic tenure_expired,
    output logic initiator_must_end,
    // Line length for line-sized commands
    input wire logic [3:0] initiator_command,
    output logic [7:0] burst_line_length,
    output logic line_sized_command
);

    // Stored fields
    logic [7:0] tenure_limit; // Bus tenure limit in clocks
    logic [7:0] line_length_setting; // Cache line length
    logic [20:0] host_window_pointer; // Host window base upper bits
    logic [20:0] ext_window_pointer; // Extension window base upper bits
    logic [7:0] tenure_count; // Clocks since frame start
    // Bytes 0Eh and 0Fh and base bits 10..0 are constants and take no flops

    // Decoded config strobes
    logic wr_tenure; // Write to the 0Ch dword
    logic wr_host; // Write to the host window base
    logic wr_ext; // Write to the extension window base
    logic rd_req; // Read of any dword this cycle

    // Tenure limit reached while our own transaction runs
    logic limit_reached;

    // Merge a write into a pointer, byte lane by byte lane
    function automatic logic [20:0] merge_pointer(input logic [20:0] old_ptr,
                                                  input logic [31:0] data,
                                                  input logic [3:0] be_n);
        logic [31:0] full;
        // Start from the stored word with the fixed low bits cleared
        full = {old_ptr, 11'h000};
        for (int i = 0; i < 4; i++) begin
            // Enabled lanes (active low) take the new byte
            if (!be_n[i]) begin
                full[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        // Only the pointer bits are kept; low bits are fixed
        return full[31:11];
    endfunction

    // Build the read word of a base register
    function automatic logic [31:0] base_word(input logic [20:0] ptr);
        // Size, prefetch, type and space fields are constants
        return {ptr, pct_pkg::WINDOW_SIZE_VALUE, pct_pkg::PREFETCH_VALUE,
                pct_pkg::LOCATABLE_VALUE, pct_pkg::SPACE_VALUE};
    endfunction

    // Does an address fall inside a 2K window
    function automatic logic window_match(input logic [20:0] ptr, input logic [31:0] addr);
        // Address bits 10..0 select a byte inside the window
        return addr[31:11] == ptr;
    endfunction

    // Memory command check; I/O, config and special cycles never hit
    function automatic logic is_mem_cmd(input logic [3:0] cmd);
        return cmd == pct_pkg::CMD_MEM_READ || cmd == pct_pkg::CMD_MEM_WRITE ||
               cmd == pct_pkg::CMD_MEM_READ_MULT || cmd == pct_pkg::CMD_MEM_READ_LINE ||
               cmd == pct_pkg::CMD_MEM_WRITE_INV;
    endfunction

    // Commands whose burst is sized by the line length
    function automatic logic is_line_cmd(input logic [3:0] cmd);
        return cmd == pct_pkg::CMD_MEM_WRITE_INV || cmd == pct_pkg::CMD_MEM_READ_LINE ||
               cmd == pct_pkg::CMD_MEM_READ_MULT;
    endfunction

    // Write strobes, one per implemented dword
    assign wr_tenure = cfg_valid && cfg_write && (cfg_dword == pct_pkg::TENURE_DWORD);
    assign wr_host = cfg_valid && cfg_write && (cfg_dword == pct_pkg::HOST_BASE_DWORD);
    assign wr_ext = cfg_valid && cfg_write && (cfg_dword == pct_pkg::EXT_BASE_DWORD);
    // Reads of any dword get an answer; unknown dwords read zero
    assign rd_req = cfg_valid && !cfg_write;

    // R3: compare count with the limit
    // Saturated count stays at or above any limit, so expiry holds until the transaction ends or a new frame starts
    assign limit_reached = initiator_active && !initiator_frame_start &&
                           (tenure_count >= tenure_limit);

    // Tenure/line register; upper half of the dword is read-only
    // Bytes 0Eh and 0Fh have no storage, so writes there leave no trace
    // Disabled lanes keep their byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // R5: clear on reset
            tenure_limit <= pct_pkg::TENURE_RESET[15:8];
            line_length_setting <= pct_pkg::TENURE_RESET[7:0];
        end else if (wr_tenure) begin
            // R4: line length lane
            if (!cfg_byte_enable_n[0]) begin
                line_length_setting <= cfg_write_data[7:0];
            end
            // R1: tenure limit lane
            if (!cfg_byte_enable_n[1]) begin
                tenure_limit <= cfg_write_data[15:8];
            end
            // Lanes 2 and 3 hold fixed bytes and are dropped
        end
    end

    // Host window base
    // Bits 10..0 are never stored; reads rebuild them from constants
    // A base of all ones is the sizing pattern and needs no special case
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // R14: host base clears
            host_window_pointer <= pct_pkg::POINTER_RESET;
        end else if (wr_host) begin
            // R9: upper bits only
            host_window_pointer <= merge_pointer(host_window_pointer, cfg_write_data,
                                                 cfg_byte_enable_n);
        end
    end

    // Extension window base
    // Same merge as the host base, so sizing reads back alike
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // R15: extension base clears
            ext_window_pointer <= pct_pkg::POINTER_RESET;
        end else if (wr_ext) begin
            // R17: enabled lanes only
            ext_window_pointer <= merge_pointer(ext_window_pointer, cfg_write_data,
                                                cfg_byte_enable_n);
        end
    end

    // Read answer strobe, one cycle after the request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_read_valid <= 1'b0;
        end else begin
            // One pulse per read
            cfg_read_valid <= rd_req;
        end
    end

    // Read data, one cycle after the request; holds between reads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_read_data <= 32'h00000000;
        end else begin
            if (rd_req) begin
                unique case (cfg_dword)
                    pct_pkg::TENURE_DWORD: begin
                        // R6: self test byte zero
                        // R7: layout byte zero
                        cfg_read_data <= {pct_pkg::SELF_TEST_VALUE, pct_pkg::LAYOUT_VALUE,
                                          tenure_limit, line_length_setting};
                    end
                    pct_pkg::HOST_BASE_DWORD: begin
                        // R8: sizing readback
                        // R10: size field zero
                        // R11: nonprefetchable
                        // R12: 32-bit locatable
                        // R13: memory space
                        cfg_read_data <= base_word(host_window_pointer);
                    end
                    pct_pkg::EXT_BASE_DWORD: begin
                        // R15: same layout
                        cfg_read_data <= base_word(ext_window_pointer);
                    end
                    default: begin
                        // Dwords outside this slice read zero
                        cfg_read_data <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Host window decode of memory cycles
    // A base left at zero still decodes; the space enable sits outside this slice
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_window_hit <= 1'b0;
        end else begin
            // R16: claim host window hits
            host_window_hit <= target_addr_valid && is_mem_cmd(target_command) &&
                               window_match(host_window_pointer, target_addr);
        end
    end

    // Extension window decode of memory cycles
    // Both windows take all five memory commands alike
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_window_hit <= 1'b0;
        end else begin
            // R16: claim extension window hits
            ext_window_hit <= target_addr_valid && is_mem_cmd(target_command) &&
                              window_match(ext_window_pointer, target_addr);
        end
    end

    // Tenure counter
    // Saturates at all ones so a long tenure cannot wrap back under the limit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tenure_count <= 8'h00;
        end else if (initiator_frame_start) begin
            // R2: restart at frame
            tenure_count <= 8'h00;
        end else if (initiator_active && tenure_count != 8'hff) begin
            // R2: count each clock
            tenure_count <= tenure_count + 8'h01;
        end
    end

    // Tenure expiry flag; a zero limit expires one clock after frame start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tenure_expired <= 1'b0;
        end else begin
            // R3: expire at limit
            tenure_expired <= limit_reached;
        end
    end

    // Release request; grant loss alone never ends a transaction early
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            initiator_must_end <= 1'b0;
        end else begin
            // R3: yield once grant removed
            initiator_must_end <= limit_reached && grant_n;
        end
    end

    // Line length handed to the initiator's burst sizing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            burst_line_length <= 8'h00;
        end else begin
            // R4: copy line length
            burst_line_length <= line_length_setting;
        end
    end

    // Flag for commands whose burst the line length sizes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_sized_command <= 1'b0;
        end else begin
            // R4: flag line commands
            line_sized_command <= is_line_cmd(initiator_command);
        end
    end

endmodule
`default_nettype wire

/* testbench/pct_sva.sv */
// Port checker for the config header slice
`timescale 1ns/10ps
`default_nettype none
module pct_sva (
    // Clock, reset, config port
    input wire logic clk, resetn, cfg_valid, cfg_write, cfg_read_valid,
    input wire logic [5:0] cfg_dword,
    input wire logic [31:0] cfg_read_data,
    // Decode, tenure, line commands
    input wire logic target_addr_valid, host_window_hit, ext_window_hit,
    input wire logic [3:0] target_command, initiator_command,
    input wire logic initiator_active, grant_n, tenure_expired,
    input wire logic initiator_must_end, line_sized_command
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_read_answer: assert property (cfg_valid && !cfg_write |=> cfg_read_valid)
        else $error("read not answered");
    a_answer_cause: assert property (cfg_read_valid |-> $past(cfg_valid && !cfg_write))
        else $error("read answer without read");
    a_host_fixed_bits: assert property (cfg_read_valid && $past(cfg_dword) == 6'h04
        |-> cfg_read_data[10:0] == 11'h000)
        else $error("host base low bits not zero");
    a_ext_fixed_bits: assert property (cfg_read_valid && $past(cfg_dword) == 6'h05
        |-> cfg_read_data[10:0] == 11'h000)
        else $error("extension base low bits not zero");
    a_fixed_bytes_zero: assert property (cfg_read_valid && $past(cfg_dword) == 6'h03
        |-> cfg_read_data[31:16] == 16'h0000)
        else $error("layout or self test byte not zero");
    a_end_cause: assert property (initiator_must_end |-> tenure_expired && $past(grant_n))
        else $error("end without expiry and grant loss");
    a_expiry_cause: assert property (tenure_expired |-> $past(initiator_active))
        else $error("expiry while idle");
    a_line_command: assert property (initiator_command inside {4'hc, 4'he, 4'hf}
        |=> line_sized_command)
        else $error("line command not flagged");
    a_no_io_hit: assert property (target_addr_valid && !target_command[2]
        |=> !host_window_hit && !ext_window_hit)
        else $error("window hit on non memory command");
endmodule
bind pct_config_header pct_sva pct_sva_i (.clk(clk), .resetn(resetn),
    .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_read_valid(cfg_read_valid),
    .cfg_dword(cfg_dword), .cfg_read_data(cfg_read_data),
    .target_addr_valid(target_addr_valid), .host_window_hit(host_window_hit),
    .ext_window_hit(ext_window_hit), .target_command(target_command),
    .initiator_command(initiator_command), .initiator_active(initiator_active),
    .grant_n(grant_n), .tenure_expired(tenure_expired),
    .initiator_must_end(initiator_must_end), .line_sized_command(line_sized_command));
`default_nettype wire

/* testbench/pct_arbiter.sv */
// Arbiter model: grants the bus, takes it back on request
`timescale 1ns/10ps
`default_nettype none
module pct_arbiter (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Take-back request and grant
    input wire logic take_back,
    output logic grant_n
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grant_n <= 1'b0;
        end else begin
            grant_n <= take_back;
        end
    end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the config header slice
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, resetn = 0, cv = 0, cw = 0, tav = 0, fs = 0, act = 0, tb = 0;
    logic [5:0] dw = 0;
    logic [3:0] ben = 0, tcmd = 0, icmd = 0;
    logic [31:0] wd = 0, taddr = 0, rdata;
    logic rv, hh, eh, gn, expd, mend, lsc;
    logic [7:0] bll;
    logic [3:0] cmds [5] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    int mismatches = 0, n_checks = 0;
    always #2 clk = ~clk;
    pct_arbiter pct_arbiter_i (.clk(clk), .resetn(resetn), .take_back(tb), .grant_n(gn));
    pct_config_header pct_config_header_i (.clk(clk), .resetn(resetn), .cfg_valid(cv),
        .cfg_write(cw), .cfg_dword(dw), .cfg_byte_enable_n(ben), .cfg_write_data(wd),
        .cfg_read_data(rdata), .cfg_read_valid(rv), .target_addr_valid(tav),
        .target_addr(taddr), .target_command(tcmd), .host_window_hit(hh),
        .ext_window_hit(eh), .initiator_frame_start(fs), .initiator_active(act),
        .grant_n(gn), .tenure_expired(expd), .initiator_must_end(mend),
        .initiator_command(icmd), .burst_line_length(bll), .line_sized_command(lsc));
    task automatic cyc(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] d, input logic [3:0] b, input logic [31:0] v);
        {cv, cw, dw, ben, wd} = {2'b11, d, b, v};
        cyc();
        {cv, cw} = 2'b00;
        cyc();
    endtask
    task automatic rd(input string what, input logic [5:0] d, input logic [31:0] e);
        {cv, dw} = {1'b1, d};
        cyc();
        cv = 0;
        chk("read valid", 1, rv);
        chk(what, e, rdata);
        cyc();
    endtask
    task automatic hit(input logic [3:0] c, input logic [31:0] a, input logic h, input logic x);
        {tav, tcmd, taddr} = {1'b1, c, a};
        cyc();
        tav = 0;
        chk("host hit", h, hh);
        chk("ext hit", x, eh);
        cyc();
    endtask
    task automatic t_registers;
        rd("tenure reset", 6'h03, 32'h0);
        rd("host reset", 6'h04, 32'h0);
        rd("ext reset", 6'h05, 32'h0);
        wr(6'h03, 4'b1110, 32'hffff_a5c3);
        rd("lane zero", 6'h03, 32'h0000_00c3);
        wr(6'h03, 4'h0, 32'hffff_a5c3);
        rd("tenure line", 6'h03, 32'h0000_a5c3);
        chk("line length", 32'h0000_00c3, {24'h0, bll});
        for (int d = 4; d < 6; d++) begin
            wr(6'(d), 4'h0, 32'hffff_ffff);
            rd("sized base", 6'(d), 32'hffff_f800);
        end
        wr(6'h04, 4'h0, 32'h1234_5fff);
        rd("host base", 6'h04, 32'h1234_5800);
        $display("registers done");
    endtask
    task automatic t_decode;
        foreach (cmds[i]) begin
            hit(cmds[i], 32'h1234_5abc, 1, 0);
            hit(cmds[i], 32'hffff_fffc, 0, 1);
            icmd = cmds[i];
            cyc();
            chk("line command", cmds[i] inside {4'hc, 4'he, 4'hf}, lsc);
        end
        hit(4'h7, 32'h1234_6000, 0, 0);
        hit(4'h2, 32'h1234_5800, 0, 0);
        $display("decode done");
    endtask
    task automatic t_tenure;
        int n;
        wr(6'h03, 4'b1101, 32'h0000_0200);
        {fs, act} = 2'b11;
        cyc();
        fs = 0;
        n = 0;
        while (expd !== 1'b1 && n < 20) begin
            cyc();
            n++;
        end
        if (n == 20) begin
            mismatches++;
            finish_test();
        end
        chk("expiry cycles", 3, n);
        chk("end while granted", 0, mend);
        tb = 1;
        cyc(2);
        chk("end after grant loss", 1, mend);
        {act, tb} = 2'b00;
        cyc(2);
        $display("tenure done");
    endtask
    task automatic t_reset;
        resetn = 0;
        cyc(2);
        chk("line length in reset", 0, {24'h0, bll});
        resetn = 1;
        rd("tenure after reset", 6'h03, 32'h0);
        rd("host after reset", 6'h04, 32'h0);
        rd("ext after reset", 6'h05, 32'h0);
        $display("reset done");
    endtask
    initial begin
        cyc(5);
        resetn = 1;
        t_registers();
        t_decode();
        t_tenure();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
